// [hw/lci_regs.svh]
// register layout, field positions, reset values and timing figures of the lcd command interface
// assumes a 100 MHz system clock; included by the package and by the core module
`ifndef LCI_REGS_SVH
`define LCI_REGS_SVH

// fixed low nibble of the slave address
`define LCI_ADDR_LOW 4'h2
// reset values of the two setup registers
`define LCI_SETUP_RST 8'h00
`define LCI_BANK_RST 8'h00
// display setup register fields
`define LCI_SU_ALLOFF 7
`define LCI_SU_ALLON 6
`define LCI_SU_ROW0 5
`define LCI_SU_ROW1 4
`define LCI_SU_ROW_COUNT_CODE_HI 1
`define LCI_SU_ROW_COUNT_CODE_LO 0
`define LCI_SU_WMASK 8'hF3
// bank pointer register fields
`define LCI_BK_PTR0 7
`define LCI_BK_PTR1 6
`define LCI_BK_PTR2 5
`define LCI_BK_WMASK 8'hE0
// control byte fields
`define LCI_CTRL_CONT 7
`define LCI_CTRL_KIND 6
`define LCI_CTRL_SEL 0
// row count codes
`define LCI_MUX_4 2'h2
`define LCI_MUX_3 2'h1
`define LCI_MUX_2 2'h0
`define LCI_MUX_1 2'h3
// pointer limits
`define LCI_LAST_BANK 3'h4
`define LCI_BANK_W 8
`define LCI_COLS 40
`define LCI_ROWS 4
// timing
`define LCI_CLK_HZ 100000000
`define LCI_FRAME_BASE_HZ 64

`endif

// [hw/lci_pkg.sv]
// types shared by the lcd command interface core
// assumes lci_regs.svh on the include path
`default_nettype none
`include "lci_regs.svh"

package lci_pkg;

    typedef enum logic [2:0] {
        LCI_IDLE,
        LCI_ADDR,
        LCI_ADDR_ACK,
        LCI_RX,
        LCI_RX_ACK,
        LCI_TX,
        LCI_TX_ACK,
        LCI_IGNORE
    } lci_state_e;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] phase_sync;
        logic [2:0] align_sync;
        logic [6:0] strap_meta;
        logic [6:0] strap_sync;
        lci_state_e state;
        logic [3:0] bit_cnt;
        logic dir_read;
        logic expect_ctrl;
        logic ctrl_cont;
        logic ctrl_kind;
        logic ctrl_sel;
        logic [7:0] tx_byte;
        logic sda_oe;
        logic sda_out;
        logic [7:0] display_setup_reg;
        logic [7:0] bank_pointer_reg;
        logic [1:0] row_ptr;
        logic [2:0] bank_ptr;
        logic disp_en;
        logic [`LCI_ROWS-1:0][`LCI_COLS-1:0] pixel_memory;
        logic [1:0] scan_row;
        logic [31:0] frame_cnt;
        logic phase_out;
        logic phase_oe;
        logic align_out;
        logic align_oe;
        logic [`LCI_ROWS-1:0] row_out;
        logic [`LCI_COLS-1:0] col_out;
    } lci_core_s;

    typedef struct packed {
        logic [7:0] shift;
    } lci_link_s;

endpackage

`default_nettype wire

// [hw/lci_command_interface.sv]
// i2c slave front end, setup registers, pixel memory and row scan of a low-mux lcd controller
// assumes scl_clk is the bus scl wire itself, all straps static, sda resolved outside
`default_nettype none
`include "lci_regs.svh"

module lci_command_interface #(
    parameter int FRAME_CYC = `LCI_CLK_HZ / `LCI_FRAME_BASE_HZ
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // i2c link
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps
    input wire logic interface_strap_hi,
    input wire logic interface_strap_lo,
    input wire logic slave_id_bit_hi,
    input wire logic slave_id_bit_mid,
    input wire logic slave_id_bit_lo,
    input wire logic phase_source_select,
    input wire logic alignment_source_select,
    // frame and alignment pins
    input wire logic phase_reversal_in,
    output logic phase_reversal_out,
    output logic phase_reversal_oe,
    input wire logic row_alignment_in,
    output logic row_alignment_out,
    output logic row_alignment_oe,
    // display drivers
    output logic [`LCI_ROWS-1:0] row_driver_out,
    output logic [`LCI_COLS-1:0] column_driver_out
);

    localparam int S_IF_HI = 0;
    localparam int S_IF_LO = 1;
    localparam int S_PH_SEL = 2;
    localparam int S_AL_SEL = 3;
    localparam int S_ID_HI = 4;
    localparam int S_ID_MID = 5;
    localparam int S_ID_LO = 6;
    localparam int STEP1 = FRAME_CYC;
    localparam int STEP2 = FRAME_CYC / 2;
    localparam int STEP3 = FRAME_CYC / 3;
    localparam int STEP4 = FRAME_CYC / 4;

    lci_pkg::lci_core_s r_reg;
    lci_pkg::lci_core_s r_next;
    lci_pkg::lci_link_s lk_reg;
    lci_pkg::lci_link_s lk_next;

    function automatic logic [1:0] lci_last_row(input logic [1:0] code);
        case (code)
            `LCI_MUX_4: lci_last_row = 2'h3;
            `LCI_MUX_3: lci_last_row = 2'h2;
            `LCI_MUX_2: lci_last_row = 2'h1;
            default: lci_last_row = 2'h0;
        endcase
    endfunction

    function automatic logic [1:0] lci_bp_row(input logic [1:0] k, input logic [1:0] code);
        case (code)
            `LCI_MUX_4: lci_bp_row = k;
            `LCI_MUX_3: lci_bp_row = (k == 2'h3) ? 2'h0 : k;
            `LCI_MUX_2: lci_bp_row = {1'b0, k[0]};
            default: lci_bp_row = 2'h0;
        endcase
    endfunction

    function automatic logic [5:0] lci_col_base(input logic [2:0] bank);
        case (bank)
            3'h0: lci_col_base = 6'h20;
            3'h1: lci_col_base = 6'h18;
            3'h2: lci_col_base = 6'h10;
            3'h3: lci_col_base = 6'h08;
            default: lci_col_base = 6'h00;
        endcase
    endfunction

    // link side: bits sampled on the real scl rise, so no oversampling jitter on data
    always_comb
    begin
        lk_next.shift = {lk_reg.shift[6:0], sda_in};
    end

    always_ff @(posedge scl_clk)
    begin
        lk_reg <= lk_next;
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic i2c_on;
    logic addr_match;
    logic [7:0] rx_byte;
    logic [1:0] last_row;
    logic frame_tick;
    logic wrap_tick;
    logic [31:0] step_cyc;

    always_comb
    begin
        r_next = r_reg;
        // two-stage synchronisers; stage 2 and its delayed copy feed the detectors
        r_next.scl_sync = {r_reg.scl_sync[1:0], scl_clk};
        r_next.sda_sync = {r_reg.sda_sync[1:0], sda_in};
        r_next.phase_sync = {r_reg.phase_sync[1:0], phase_reversal_in};
        r_next.align_sync = {r_reg.align_sync[1:0], row_alignment_in};
        r_next.strap_meta = {slave_id_bit_lo, slave_id_bit_mid, slave_id_bit_hi,
            alignment_source_select, phase_source_select, interface_strap_lo,
            interface_strap_hi};
        r_next.strap_sync = r_reg.strap_meta;
        scl_rise = r_reg.scl_sync[1] & ~r_reg.scl_sync[2];
        scl_fall = ~r_reg.scl_sync[1] & r_reg.scl_sync[2];
        start_det = r_reg.scl_sync[1] & r_reg.scl_sync[2]
            & ~r_reg.sda_sync[1] & r_reg.sda_sync[2];
        stop_det = r_reg.scl_sync[1] & r_reg.scl_sync[2]
            & r_reg.sda_sync[1] & ~r_reg.sda_sync[2];
        i2c_on = r_reg.strap_sync[S_IF_HI] & r_reg.strap_sync[S_IF_LO];
        // link shifter is stable for the whole scl low time after the eighth rise
        rx_byte = lk_reg.shift;
        addr_match = rx_byte[7:1] == {r_reg.strap_sync[S_ID_HI], r_reg.strap_sync[S_ID_MID],
            r_reg.strap_sync[S_ID_LO], `LCI_ADDR_LOW};
        last_row = lci_last_row({r_reg.display_setup_reg[`LCI_SU_ROW_COUNT_CODE_HI],
            r_reg.display_setup_reg[`LCI_SU_ROW_COUNT_CODE_LO]});
        r_next.sda_out = 1'b0;

        if (!i2c_on)
        begin
            r_next.state = lci_pkg::LCI_IDLE;
            r_next.sda_oe = 1'b0;
        end
        else if (start_det)
        begin
            r_next.state = lci_pkg::LCI_ADDR;
            r_next.bit_cnt = 4'h0;
            r_next.sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            r_next.state = lci_pkg::LCI_IDLE;
            r_next.sda_oe = 1'b0;
        end
        else
        begin
            if (scl_rise)
            begin
                r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
            end
            case (r_reg.state)
                lci_pkg::LCI_ADDR:
                begin
                    if (scl_fall && r_reg.bit_cnt == 4'h8)
                    begin
                        if (addr_match)
                        begin
                            r_next.sda_oe = 1'b1;
                            r_next.dir_read = rx_byte[0];
                            r_next.state = lci_pkg::LCI_ADDR_ACK;
                        end
                        else
                        begin
                            r_next.state = lci_pkg::LCI_IGNORE;
                        end
                    end
                end
                lci_pkg::LCI_ADDR_ACK:
                begin
                    if (scl_fall && r_reg.bit_cnt == 4'h9)
                    begin
                        r_next.bit_cnt = 4'h0;
                        if (r_reg.dir_read)
                        begin
                            r_next.tx_byte = r_reg.display_setup_reg;
                            r_next.sda_oe = ~r_reg.display_setup_reg[7];
                            r_next.state = lci_pkg::LCI_TX;
                        end
                        else
                        begin
                            r_next.sda_oe = 1'b0;
                            r_next.expect_ctrl = 1'b1;
                            r_next.state = lci_pkg::LCI_RX;
                        end
                    end
                end
                lci_pkg::LCI_RX:
                begin
                    if (scl_fall && r_reg.bit_cnt == 4'h8)
                    begin
                        r_next.sda_oe = 1'b1;
                        r_next.state = lci_pkg::LCI_RX_ACK;
                        if (r_reg.expect_ctrl)
                        begin
                            if (rx_byte[5:1] != 5'h00)
                            begin
                                r_next.sda_oe = 1'b0;
                                r_next.state = lci_pkg::LCI_IGNORE;
                            end
                            r_next.ctrl_cont = rx_byte[`LCI_CTRL_CONT];
                            r_next.ctrl_kind = rx_byte[`LCI_CTRL_KIND];
                            r_next.ctrl_sel = rx_byte[`LCI_CTRL_SEL];
                            r_next.expect_ctrl = 1'b0;
                        end
                        else
                        begin
                            r_next.expect_ctrl = r_reg.ctrl_cont;
                            if (r_reg.ctrl_kind)
                            begin
                                r_next.pixel_memory[r_reg.row_ptr][lci_col_base(r_reg.bank_ptr)
                                    +: `LCI_BANK_W] = rx_byte;
                                if (r_reg.bank_ptr >= `LCI_LAST_BANK)
                                begin
                                    r_next.bank_ptr = 3'h0;
                                    r_next.row_ptr = (r_reg.row_ptr >= last_row) ? 2'h0
                                        : 2'(r_reg.row_ptr + 2'h1);
                                end
                                else
                                begin
                                    r_next.bank_ptr = 3'(r_reg.bank_ptr + 3'h1);
                                end
                            end
                            else if (!r_reg.ctrl_sel)
                            begin
                                r_next.display_setup_reg = rx_byte & `LCI_SU_WMASK;
                                r_next.row_ptr = {rx_byte[`LCI_SU_ROW1],
                                    rx_byte[`LCI_SU_ROW0]};
                                r_next.disp_en = 1'b1;
                            end
                            else
                            begin
                                r_next.bank_pointer_reg = rx_byte & `LCI_BK_WMASK;
                                r_next.bank_ptr = {rx_byte[`LCI_BK_PTR2], rx_byte[`LCI_BK_PTR1],
                                    rx_byte[`LCI_BK_PTR0]};
                                r_next.disp_en = 1'b1;
                            end
                        end
                    end
                end
                lci_pkg::LCI_RX_ACK:
                begin
                    if (scl_fall && r_reg.bit_cnt == 4'h9)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.bit_cnt = 4'h0;
                        r_next.state = lci_pkg::LCI_RX;
                    end
                end
                lci_pkg::LCI_TX:
                begin
                    if (scl_fall)
                    begin
                        if (r_reg.bit_cnt == 4'h8)
                        begin
                            r_next.sda_oe = 1'b0;
                            r_next.state = lci_pkg::LCI_TX_ACK;
                        end
                        else
                        begin
                            r_next.tx_byte = {r_reg.tx_byte[6:0], 1'b0};
                            r_next.sda_oe = ~r_reg.tx_byte[6];
                        end
                    end
                end
                lci_pkg::LCI_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        r_next.state = lci_pkg::LCI_IGNORE;
                    end
                end
                default:
                begin
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end

        // row scan timing
        case (last_row)
            2'h3: step_cyc = 32'(STEP4);
            2'h2: step_cyc = 32'(STEP3);
            2'h1: step_cyc = 32'(STEP2);
            default: step_cyc = 32'(STEP1);
        endcase
        r_next.phase_oe = ~r_reg.strap_sync[S_PH_SEL];
        r_next.align_oe = ~r_reg.strap_sync[S_AL_SEL];
        r_next.align_out = 1'b0;
        frame_tick = 1'b0;
        if (!r_reg.strap_sync[S_PH_SEL])
        begin
            // internal frame: one row step per tick, 64 Hz times mux rate
            if (r_reg.frame_cnt >= 32'(step_cyc - 32'h1))
            begin
                r_next.frame_cnt = 32'h0;
                frame_tick = 1'b1;
            end
            else
            begin
                r_next.frame_cnt = 32'(r_reg.frame_cnt + 32'h1);
            end
        end
        else
        begin
            r_next.frame_cnt = 32'h0;
            frame_tick = r_reg.phase_sync[1] ^ r_reg.phase_sync[2];
        end
        wrap_tick = frame_tick && r_reg.scan_row >= last_row;
        if (frame_tick)
        begin
            r_next.scan_row = wrap_tick ? 2'h0 : 2'(r_reg.scan_row + 2'h1);
        end
        if (wrap_tick && !r_reg.strap_sync[S_PH_SEL])
        begin
            r_next.phase_out = ~r_reg.phase_out;
        end
        if (wrap_tick && !r_reg.strap_sync[S_AL_SEL])
        begin
            r_next.align_out = 1'b1;
        end
        if (r_reg.strap_sync[S_AL_SEL] && r_reg.align_sync[1] && !r_reg.align_sync[2])
        begin
            r_next.scan_row = 2'h0;
        end
        // all drivers stay grounded until a setup command arrives
        for (int k = 0; k < `LCI_ROWS; k++)
        begin
            r_next.row_out[k] = r_reg.disp_en && r_reg.scan_row == lci_bp_row(2'(k),
                {r_reg.display_setup_reg[`LCI_SU_ROW_COUNT_CODE_HI], r_reg.display_setup_reg[`LCI_SU_ROW_COUNT_CODE_LO]});
        end
        if (!r_reg.disp_en || r_reg.display_setup_reg[`LCI_SU_ALLOFF])
        begin
            r_next.col_out = '0;
        end
        else if (r_reg.display_setup_reg[`LCI_SU_ALLON])
        begin
            r_next.col_out = '1;
        end
        else
        begin
            r_next.col_out = r_reg.pixel_memory[r_reg.scan_row];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
            r_reg.display_setup_reg <= `LCI_SETUP_RST;
            r_reg.bank_pointer_reg <= `LCI_BANK_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign sda_out = r_reg.sda_out;
    assign sda_oe = r_reg.sda_oe;
    assign phase_reversal_out = r_reg.phase_out;
    assign phase_reversal_oe = r_reg.phase_oe;
    assign row_alignment_out = r_reg.align_out;
    assign row_alignment_oe = r_reg.align_oe;
    assign row_driver_out = r_reg.row_out;
    assign column_driver_out = r_reg.col_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_addr_end;
        r_reg.state == lci_pkg::LCI_ADDR && scl_fall && r_reg.bit_cnt == 4'h8 && i2c_on
            && !start_det && !stop_det;
    endsequence

    sequence s_read_go;
        r_reg.state == lci_pkg::LCI_ADDR_ACK && scl_fall && r_reg.bit_cnt == 4'h9
            && r_reg.dir_read && i2c_on && !start_det && !stop_det;
    endsequence

    AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    AST_OFF_NO_DRIVE: assert property (!i2c_on |=> !sda_oe)
        else $error("sda driven while interface strapped off");
    AST_ADDR_ACK: assert property (s_addr_end ##0 addr_match |=> sda_oe ##0 r_reg.state == lci_pkg::LCI_ADDR_ACK)
        else $error("matching address not acknowledged");
    AST_ADDR_NOMATCH: assert property (s_addr_end ##0 !addr_match |=> !sda_oe && r_reg.state == lci_pkg::LCI_IGNORE)
        else $error("foreign address touched the bus");
    AST_START_SEEN: assert property (i2c_on && start_det |=> r_reg.state == lci_pkg::LCI_ADDR && r_reg.bit_cnt == 4'h0)
        else $error("start condition missed");
    AST_STATUS_MSB: assert property (s_read_go |=> sda_oe == !r_reg.display_setup_reg[7] && r_reg.state == lci_pkg::LCI_TX)
        else $error("status byte msb wrong");
    AST_BLANK_WINS: assert property (r_reg.disp_en && r_reg.display_setup_reg[7] |=> column_driver_out == '0)
        else $error("blank did not clear columns");
    AST_SET_ON: assert property (r_reg.disp_en && !r_reg.display_setup_reg[7] && r_reg.display_setup_reg[6] |=> column_driver_out == '1)
        else $error("set did not light columns");
    AST_IDLE_DRIVERS: assert property (!r_reg.disp_en |=> row_driver_out == '0 && column_driver_out == '0)
        else $error("drivers active before setup");
    AST_RESET_CLEAR: assert property ($past(rst) |-> r_reg.row_ptr == 2'h0 && r_reg.bank_ptr == 3'h0 && row_driver_out == '0 ##1 column_driver_out == '0)
        else $error("reset state wrong");
    AST_BANK_WRAP: assert property (r_reg.state == lci_pkg::LCI_RX && scl_fall && r_reg.bit_cnt == 4'h8 && !r_reg.expect_ctrl && r_reg.ctrl_kind && r_reg.bank_ptr == `LCI_LAST_BANK && i2c_on && !start_det && !stop_det |=> r_reg.bank_ptr == 3'h0)
        else $error("bank pointer did not wrap");

endmodule

`default_nettype wire

// [tb/lci_master.sv]
// i2c bus master model: makes scl and pulls sda low, never drives it high
// assumes the bench resolves sda from every pull-down with a pull-up
`default_nettype none
module lci_master (
    // bus
    output var logic scl,
    output var logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 700;
    localparam int H = 300;
    // extra low time, lets the bench run the bus slowly
    int slow = 0;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // data moves only while scl is low, after the hold time
    task automatic pulse(input logic b, output logic s);
        #(H + slow) sda_pull = !b;
        #T scl = 1'b1;
        #T s = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_pull = 1'b1;
        #T scl = 1'b0;
    endtask
    task automatic stop();
        #H sda_pull = 1'b1;
        #T scl = 1'b1;
        #T sda_pull = 1'b0;
        #(T + H);
    endtask
    // reading passes 8'hFF, so sda stays released and the ninth pulse is a nack
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            pulse(d[i], q[i]);
        pulse(1'b1, a);
        ack = !a;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the lcd command interface against an i2c master model
// assumes straps 101 give write address 8'hA4; frame count cut to 400 clocks
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pss = 1'b0;
    logic ass = 1'b0;
    logic ifs_lo = 1'b1;
    logic fr_in = 1'b0;
    logic al_in = 1'b0;
    logic al_out;
    logic scl, m_pull, sda_oe, sda_out, fr_out, fr_oe, al_oe, ack;
    logic [3:0] rows;
    logic [39:0] cols;
    logic [7:0] q;
    int err_total = 0;
    int checked = 0;
    wire sda = !(m_pull | sda_oe);
    always #5 clk = !clk;
    lci_master u_lci_master (.scl(scl), .sda_pull(m_pull), .sda(sda));
    lci_command_interface #(.FRAME_CYC(400)) u_lci_command_interface (
        .clk(clk), .rst(rst), .scl_clk(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .interface_strap_hi(1'b1), .interface_strap_lo(ifs_lo),
        .slave_id_bit_hi(1'b1), .slave_id_bit_mid(1'b0), .slave_id_bit_lo(1'b1),
        .phase_source_select(pss), .alignment_source_select(ass),
        .phase_reversal_in(fr_in), .phase_reversal_out(fr_out),
        .phase_reversal_oe(fr_oe), .row_alignment_in(al_in), .row_alignment_out(al_out),
        .row_alignment_oe(al_oe), .row_driver_out(rows), .column_driver_out(cols));
    task automatic check(string name, logic [39:0] seen, logic [39:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // first n_ok bytes, address included, must be acked
    task automatic wr(logic [7:0] b[$], int n_ok);
        u_lci_master.start();
        foreach (b[i])
        begin
            u_lci_master.xfer(b[i], q, ack);
            check("write ack", ack, i < n_ok);
        end
        u_lci_master.stop();
    endtask
    task automatic rd(logic [7:0] exp);
        u_lci_master.start();
        u_lci_master.xfer(8'hA5, q, ack);
        check("read addr ack", ack, 1'b1);
        u_lci_master.xfer(8'hFF, q, ack);
        check("status", q, exp);
        check("released", ack, 1'b0);
        u_lci_master.stop();
    endtask
    task automatic t_reset();
        check("rows idle", rows, 4'h0);
        check("cols idle", cols, 40'h0);
        check("frame oe", fr_oe, 1'b1);
        check("align oe", al_oe, 1'b1);
        rd(8'h00);
        repeat (1000) @(negedge clk);
        check("no drive before setup", cols, 40'h0);
    endtask
    task automatic t_setup();
        wr('{8'hA4, 8'h80, 8'h41}, 3);
        rd(8'h41);
        repeat (1000) @(negedge clk);
        check("all on", cols, {40{1'b1}});
        wr('{8'hA4, 8'h80, 8'hCE}, 3);
        rd(8'hC2);
        repeat (1000) @(negedge clk);
        check("all off", cols, 40'h0);
    endtask
    task automatic t_refuse();
        u_lci_master.slow = 2000;
        wr('{8'h24, 8'h80, 8'h00}, 0);
        wr('{8'hAC}, 0);
        u_lci_master.slow = 0;
        @(negedge clk);
        ifs_lo = 1'b0;
        repeat (10) @(negedge clk);
        wr('{8'hA4}, 0);
        @(negedge clk);
        ifs_lo = 1'b1;
        repeat (10) @(negedge clk);
        wr('{8'hA4, 8'h82, 8'h00}, 1);
        rd(8'hC2);
    endtask
    task automatic t_pixels();
        wr('{8'hA4, 8'h80, 8'h03, 8'h81, 8'h20, 8'h40, 8'h5A, 8'h3C}, 8);
        repeat (1000) @(negedge clk);
        check("rows static", rows, 4'hF);
        check("last bank", cols[7:0], 8'h5A);
        check("wrap bank", cols[39:32], 8'h3C);
        rd(8'h03);
    endtask
    task automatic t_frame();
        logic f;
        int n;
        @(fr_out);
        @(negedge clk);
        f = fr_out;
        for (n = 1; n < 2000 && fr_out === f; n++)
            @(negedge clk);
        check("frame half period", n - 1, 400);
    endtask
    task automatic t_straps();
        pss = 1'b1;
        ass = 1'b1;
        repeat (10) @(negedge clk);
        check("frame input", fr_oe, 1'b0);
        check("align input", al_oe, 1'b0);
        check("open drain", sda_out, 1'b0);
        check("no internal align", al_out, 1'b0);
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_reset();
        t_setup();
        t_refuse();
        t_pixels();
        t_frame();
        t_straps();
        test_done();
    end
    // the sequence needs about 650 us
    initial
    begin
        #900000;
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
